// file: hdl/adc_mode_conversion_control.sv
// Purpose: Mode register, conversion sequencing and serial result output
// Assumes: Host drives serial clock and data synchronous to sys_clk
// Notes:   Serial clock idles high; data shifts on falling edge,
//          host samples on rising edge; MSB first
`timescale 1ns/1ns
`default_nettype none
module adc_mode_conversion_control #(
  parameter int PERIOD = conv_ctrl_pkg::PERIOD_CYCLES,
  parameter int WIDTH  = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             serial_clk,
  input  wire logic             serial_in,
  input  wire logic             chip_select_n,
  input  wire logic [WIDTH-1:0] sample_in,
  output var  logic             serial_out,
  output var  logic             ready_n,
  output var  logic             converter_power,
  output var  logic             filter_reset,
  output var  conv_ctrl_pkg::analog_ctrl_type analog_ctrl,
  output var  logic             burnout_on
);

  // Data word needs room for an 8-bit register image plus padding
  if (PERIOD < 2 || WIDTH < 9 || WIDTH > 31) begin : g_bad_params
    $error("Unsupported parameter values");
  end

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_CONVERT} conv_state_type;
  typedef enum {SH_CMD, SH_WRITE, SH_READ} shift_state_type;

  conv_state_type  conv_state;
  shift_state_type sh_state;
  logic [7:0]       mode_reg;
  logic [7:0]       filter_reg;
  logic [31:0]      period_cnt;
  logic [1:0]       periods_done;
  logic             cont_read;
  logic [1:0]       target_sel;
  logic [WIDTH-1:0] shift_reg;
  logic [4:0]       bit_cnt;
  logic [4:0]       bit_total;
  logic             sclk_q;
  logic [WIDTH-1:0] data_q;
  logic             read_pending;

  wire sclk_rise  = serial_clk & ~sclk_q & ~chip_select_n;
  wire sclk_fall  = ~serial_clk & sclk_q & ~chip_select_n;
  wire [1:0] mode = mode_reg[conv_ctrl_pkg::MODE_HI:conv_ctrl_pkg::MODE_LO];

  wire mode_cont   = (mode == conv_ctrl_pkg::MD_CONT);
  wire mode_single = (mode == conv_ctrl_pkg::MD_SINGLE);
  wire mode_down   = (mode == conv_ctrl_pkg::MD_DOWN);

  wire [7:0] rx_byte  = {shift_reg[6:0], serial_in};
  wire       byte_end = sclk_rise && (bit_cnt == 5'd7);
  wire       cmd_done = (sh_state == SH_CMD) && byte_end && !cont_read;
  wire       cmd_read = rx_byte[conv_ctrl_pkg::COMM_RW_BIT];
  wire [1:0] cmd_sel  =
    rx_byte[conv_ctrl_pkg::COMM_RS_HI:conv_ctrl_pkg::COMM_RS_LO];
  wire       wr_done  = (sh_state == SH_WRITE) && byte_end;
  wire       mode_wr  = wr_done && (target_sel == conv_ctrl_pkg::SEL_MODE);
  wire       rd_end   = (sh_state == SH_READ) && sclk_rise &&
                        (bit_cnt == bit_total - 5'd1);
  wire       data_read = rd_end && (target_sel == conv_ctrl_pkg::SEL_DATA);

  wire period_end = (period_cnt == 32'(PERIOD - 1));
  wire conv_done  = (conv_state == ST_CONVERT) && period_end &&
                    (periods_done != 2'd0);
  wire [7:0] status_byte = {ready_n, 1'b0, 6'(conv_ctrl_pkg::STAT_FIXED)};

  localparam logic [WIDTH-9:0] LOW_PAD = '0;

  function automatic logic [WIDTH-1:0] load_word(input logic [1:0] sel,
                                                 input logic [WIDTH-1:0] d);
    case (sel)
      conv_ctrl_pkg::SEL_COMM:   load_word = {status_byte, LOW_PAD};
      conv_ctrl_pkg::SEL_MODE:   load_word = {mode_reg, LOW_PAD};
      conv_ctrl_pkg::SEL_FILTER: load_word = {filter_reg, LOW_PAD};
      default:                   load_word = d;
    endcase
  endfunction

  // Mode register bits to analog control fields
  function automatic conv_ctrl_pkg::analog_ctrl_type ctrl_of(
    input logic [7:0] r);
    return {r[conv_ctrl_pkg::MODE_HI:conv_ctrl_pkg::SPAN_LO],
            r[conv_ctrl_pkg::BO_BIT], r[conv_ctrl_pkg::BUF_BIT]};
  endfunction

  result_store #(.WIDTH(WIDTH)) u_store (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wr_en   (conv_done),
    .wr_data (sample_in),
    .rd_data (data_q)
  );

  // ----------------------------------------------------------------------
  // Mode register and analog controls
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg   <= conv_ctrl_pkg::MODE_RESET;
      filter_reg <= conv_ctrl_pkg::FILT_RESET;
    end else if (wr_done) begin
      if (target_sel == conv_ctrl_pkg::SEL_MODE) begin
        mode_reg <= rx_byte;
      end
      if (target_sel == conv_ctrl_pkg::SEL_FILTER) begin
        filter_reg <= rx_byte;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // analog controls follow the register's reset value
      analog_ctrl <= ctrl_of(conv_ctrl_pkg::MODE_RESET);
      burnout_on  <= 1'b0;
    end else begin
      analog_ctrl <= ctrl_of(mode_reg);
      burnout_on <= mode_reg[conv_ctrl_pkg::BO_BIT] &
                    mode_reg[conv_ctrl_pkg::BUF_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_state   <= ST_CONVERT;
      period_cnt   <= '0;
      periods_done <= '0;
    end else if (mode_wr) begin
      // restart filter; single mode starts a conversion
      period_cnt   <= '0;
      periods_done <= '0;
      conv_state   <= (rx_byte[conv_ctrl_pkg::MODE_HI:conv_ctrl_pkg::MODE_LO]
                       inside {conv_ctrl_pkg::MD_CONT,
                               conv_ctrl_pkg::MD_SINGLE})
                      ? ST_CONVERT : ST_IDLE;
    end else begin
      case (conv_state)
        ST_CONVERT: begin
          period_cnt <= period_end ? '0 : period_cnt + 32'd1;
          if (period_end && periods_done == 2'd0) begin
            periods_done <= 2'd1;
          end
          // back to back in continuous; single stops
          if (conv_done && !mode_cont) begin
            conv_state <= ST_IDLE;
          end
          // no conversion in power-down or reserved
          if (!(mode_cont || mode_single)) begin
            conv_state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          period_cnt   <= '0;
          periods_done <= '0;
        end
        default: conv_state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      converter_power <= 1'b0;
      filter_reset    <= 1'b1;
    end else begin
      converter_power <= (conv_state == ST_CONVERT) && !mode_wr;
      filter_reset    <= mode_wr;
    end
  end

  // ----------------------------------------------------------------------
  // Ready indication
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ready_n <= 1'b1;
    end else if (conv_done) begin
      // low on new result; new result wins over a read
      ready_n <= 1'b0;
    end else if (mode_wr || data_read || mode_down) begin
      ready_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Serial interface
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_q       <= 1'b1;
      sh_state     <= SH_CMD;
      shift_reg    <= '0;
      bit_cnt      <= '0;
      bit_total    <= 5'd8;
      target_sel   <= conv_ctrl_pkg::SEL_COMM;
      cont_read    <= 1'b0;
      serial_out   <= 1'b1;
      read_pending <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
      if (chip_select_n) begin
        bit_cnt <= '0;
      end
      case (sh_state)
        SH_CMD: begin
          if (cont_read && read_pending && sh_state == SH_CMD) begin
            sh_state     <= SH_READ;
            target_sel   <= conv_ctrl_pkg::SEL_DATA;
            bit_total    <= 5'(WIDTH);
            shift_reg    <= data_q;
            bit_cnt      <= '0;
            read_pending <= 1'b0;
          end else if (sclk_rise) begin
            shift_reg <= {shift_reg[WIDTH-2:0], serial_in};
            bit_cnt   <= bit_cnt + 5'd1;
          end
          if (cmd_done) begin
            bit_cnt    <= '0;
            target_sel <= cmd_sel;
            if (cmd_read) begin
              // read command loads the addressed register
              sh_state  <= SH_READ;
              bit_total <= (cmd_sel == conv_ctrl_pkg::SEL_DATA)
                           ? 5'(WIDTH) : 5'd8;
              shift_reg <= load_word(cmd_sel, data_q);
              cont_read <= (cmd_sel == conv_ctrl_pkg::SEL_DATA) &&
                           rx_byte[conv_ctrl_pkg::COMM_CREAD_BIT];
            end else if (cmd_sel != conv_ctrl_pkg::SEL_COMM) begin
              sh_state <= SH_WRITE;
            end
          end
        end
        SH_WRITE: begin
          if (sclk_rise) begin
            shift_reg <= {shift_reg[WIDTH-2:0], serial_in};
            bit_cnt   <= bit_cnt + 5'd1;
          end
          if (wr_done) begin
            sh_state <= SH_CMD;
            bit_cnt  <= '0;
          end
        end
        SH_READ: begin
          if (sclk_fall) begin
            serial_out <= shift_reg[WIDTH-1];
            shift_reg  <= {shift_reg[WIDTH-2:0], 1'b0};
          end
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 5'd1;
          end
          if (rd_end) begin
            sh_state   <= SH_CMD;
            bit_cnt    <= '0;
            serial_out <= 1'b1;
          end
        end
        default: sh_state <= SH_CMD;
      endcase
      // new result queued; set wins so a result is never lost
      if (conv_done && cont_read) begin
        read_pending <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence mode_write_seq;
    mode_wr;
  endsequence

  chk_ready_low_on_result: assert property (@(posedge sys_clk)
    disable iff (sys_rst) conv_done |=> !ready_n)
    else $error("ready not low after result");
  chk_ready_high_write: assert property (@(posedge sys_clk)
    disable iff (sys_rst) mode_write_seq ##0 !conv_done |=> ready_n)
    else $error("ready not high after mode write");
  chk_ready_high_read: assert property (@(posedge sys_clk)
    disable iff (sys_rst) data_read && !conv_done |=> ready_n)
    else $error("ready not high after read");
  chk_ready_high_down: assert property (@(posedge sys_clk)
    disable iff (sys_rst) mode_down && !conv_done |=> ready_n)
    else $error("ready not high in power-down");
  chk_burnout_gate: assert property (@(posedge sys_clk)
    disable iff (sys_rst) burnout_on |-> analog_ctrl.buffer_enable)
    else $error("burnout without buffer");
  chk_down_no_conv: assert property (@(posedge sys_clk)
    disable iff (sys_rst) $past(mode_down) && mode_down |-> !conv_done)
    else $error("conversion in power-down");
  chk_single_power: assert property (@(posedge sys_clk)
    disable iff (sys_rst) mode_single && conv_done && !mode_wr
    |=> ##1 !converter_power)
    else $error("single mode stays powered");
  chk_single_hold: assert property (@(posedge sys_clk)
    disable iff (sys_rst) mode_single && conv_done && !mode_wr
    ##1 (!mode_wr && !data_read && !mode_down)[*4] |-> !ready_n)
    else $error("ready not held after single");
  chk_mode_reset: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> mode_reg == conv_ctrl_pkg::MODE_RESET)
    else $error("mode reset value wrong");

endmodule
`default_nettype wire

// file: hdl/conv_ctrl_pkg.sv
// Purpose: Shared constants and types for the conversion mode control block
// Assumes: Single 50 MHz clock, synchronous active-high reset
// Notes:   Serial interface runs on the device clock; pin inputs are synchronous
package conv_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register selection and mode register layout
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_COMM   = 2'h0;
  localparam logic [1:0] SEL_MODE   = 2'h1;
  localparam logic [1:0] SEL_FILTER = 2'h2;
  localparam logic [1:0] SEL_DATA   = 2'h3;

  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] FILT_RESET = 8'h04;
  localparam logic [7:0] STAT_FIXED = 8'h08;

  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int SPAN_HI = 5;
  localparam int SPAN_LO = 4;
  localparam int BO_BIT  = 3;
  localparam int BUF_BIT = 1;

  // Communications register fields
  localparam int COMM_RW_BIT  = 3;
  localparam int COMM_RS_HI   = 5;
  localparam int COMM_RS_LO   = 4;
  localparam int COMM_CREAD_BIT = 2;

  localparam logic [1:0] MD_CONT  = 2'h0;
  localparam logic [1:0] MD_RSVD  = 2'h1;
  localparam logic [1:0] MD_SINGLE = 2'h2;
  localparam logic [1:0] MD_DOWN  = 2'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int RATE_DEF_HZ   = 120;
  localparam int PERIOD_CYCLES = CLK_HZ / RATE_DEF_HZ;
  localparam int SETTLE_PERIODS = 2;

  typedef struct packed {
    logic [1:0] conversion_mode_field;
    logic [1:0] input_span_field;
    logic       burnout_current_enable;
    logic       buffer_enable;
  } analog_ctrl_type;

endpackage

// file: hdl/result_store.sv
// Purpose: Data register holding the latest conversion result
// Assumes: Write and read are synchronous to sys_clk
// Notes:   Read data comes out of a register
`timescale 1ns/1ns
`default_nettype none
module result_store #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic [WIDTH-1:0] rd_data
);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule
`default_nettype wire

// file: tb/adc_mode_conversion_control_tb.sv
// Purpose: Self-checking bench for the conversion mode control block
// Assumes: Short conversion period for simulation
// Notes:   Host model drives all serial traffic
`timescale 1ns/1ns
`default_nettype none
module adc_mode_conversion_control_tb;
  localparam int PER = 200;
  logic        sys_clk;
  logic        sys_rst;
  logic        serial_clk;
  logic        serial_in;
  logic        chip_select_n;
  logic        serial_out;
  logic        ready_n;
  logic        converter_power;
  logic        filter_reset;
  logic        burnout_on;
  logic        fr_seen;
  logic        pw_seen;
  logic [15:0] sample_in;
  logic [15:0] rx;
  logic [7:0]  v;
  int          bad_count;
  int          checks;
  int          cyc;
  int          t0;
  conv_ctrl_pkg::analog_ctrl_type analog_ctrl;

  adc_mode_conversion_control #(.PERIOD(PER), .WIDTH(16)) i_dut (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .serial_clk      (serial_clk),
    .serial_in       (serial_in),
    .chip_select_n   (chip_select_n),
    .sample_in       (sample_in),
    .serial_out      (serial_out),
    .ready_n         (ready_n),
    .converter_power (converter_power),
    .filter_reset    (filter_reset),
    .analog_ctrl     (analog_ctrl),
    .burnout_on      (burnout_on)
  );
  serial_host_model i_host (
    .sys_clk       (sys_clk),
    .serial_out    (serial_out),
    .serial_clk    (serial_clk),
    .serial_in     (serial_in),
    .chip_select_n (chip_select_n)
  );
  // --------------------------------------------------------------
  // Clock, monitors and helpers
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Sticky flags catch one-cycle pulses between host calls
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (filter_reset) fr_seen <= 1'b1;
    if (converter_power) pw_seen <= 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (ready_n !== 1'b0 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(ready_n), 16'h0000);
  endtask
  // Loose window: the exact edge of a result is the design's choice
  task automatic near(input int exp, input int tol);
    check(16'(cyc - t0 >= exp - tol && cyc - t0 <= exp + tol), 16'h0001);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    sys_rst   = 1'b1;
    sample_in = 16'hA5C3;
    bad_count = 0;
    checks    = 0;
    cyc       = 0;
    fr_seen   = 1'b0;
    pw_seen   = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(16'(analog_ctrl), 16'h0001);
    check(16'({serial_out, ready_n, converter_power, burnout_on}),
          16'h000C);
    sys_rst = 1'b0;
    t0      = cyc;
    i_host.read_reg(8'h18, 8, rx);
    check(rx, 16'h0002);
    i_host.read_reg(8'h08, 8, rx);
    check(rx, 16'h0088);
    i_host.read_reg(8'h28, 8, rx);
    check(rx, 16'(conv_ctrl_pkg::FILT_RESET));
    wait_rdy(3 * PER);
    near(2 * PER, 4);
    t0 = cyc;
    i_host.read_reg(8'h38, 16, rx);
    check(rx, 16'hA5C3);
    check(16'(ready_n), 16'h0001);
    sample_in = 16'h3C5A;
    wait_rdy(PER);
    near(PER, 4);
    i_host.read_reg(8'h38, 16, rx);
    check(rx, 16'h3C5A);
    sample_in = 16'h1234;
    fr_seen   = 1'b0;
    i_host.write_mode(8'h82);
    t0 = cyc;
    check(16'({fr_seen, ready_n, converter_power}), 16'h0007);
    check(16'(analog_ctrl.conversion_mode_field), 16'h0002);
    wait_rdy(3 * PER);
    near(2 * PER, 8);
    repeat (4) @(negedge sys_clk);
    pw_seen = 1'b0;
    repeat (3 * PER) @(negedge sys_clk);
    check(16'({pw_seen, ready_n}), 16'h0000);
    for (int m = 0; m < 2; m++) begin
      v = m ? 8'h42 : 8'hC2;
      i_host.write_mode(v);
      pw_seen = 1'b0;
      check(16'(ready_n), 16'h0001);
      repeat (3 * PER) @(negedge sys_clk);
      check(16'({pw_seen, ready_n}), 16'h0001);
    end
    i_host.read_reg(8'h38, 16, rx);
    check(rx, 16'h1234);
    check(16'(ready_n), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      v = {2'b11, i[1:0], i[2], 1'b1, ~i[0], 1'b1};
      i_host.write_mode(v);
      check(16'(analog_ctrl), 16'({v[7:3], v[1]}));
      check(16'(burnout_on), 16'(v[3] & v[1]));
    end
    sample_in = 16'hBEEF;
    i_host.write_mode(8'h02);
    wait_rdy(3 * PER);
    i_host.read_reg(8'h3C, 16, rx);
    check(rx, 16'hBEEF);
    sample_in = 16'h7E81;
    wait_rdy(2 * PER);
    i_host.stream(rx);
    check(rx, 16'h7E81);
    finish_test();
  end
endmodule
`default_nettype wire

// file: tb/serial_host_model.sv
// Purpose: Host model on the four-wire serial interface
// Assumes: Serial edges at least two system clocks apart
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output var  logic serial_clk,
  output var  logic serial_in,
  output var  logic chip_select_n
);
  initial begin
    serial_clk    = 1'b1;
    serial_in     = 1'b1;
    chip_select_n = 1'b1;
  end
  // --------------------------------------------------------------
  // Bit level transfer
  // --------------------------------------------------------------
  // Data held from fall to rise; reply taken at the rise
  task automatic shift(input int n, input logic [15:0] tx,
                       output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge sys_clk);
      chip_select_n = 1'b0;
      serial_clk    = 1'b0;
      serial_in     = tx[i];
      repeat (3) @(negedge sys_clk);
      serial_clk = 1'b1;
      rx         = {rx[14:0], serial_out};
      @(negedge sys_clk);
    end
  endtask
  // Released line must not keep its last value
  task automatic release_bus();
    @(negedge sys_clk);
    chip_select_n = 1'b1;
    serial_in     = ~serial_in;
  endtask
  task automatic write_mode(input logic [7:0] v);
    logic [15:0] rx;
    shift(8, 16'h0010, rx);
    shift(8, {8'h00, v & 8'hFA}, rx);
    release_bus();
  endtask
  task automatic read_reg(input logic [7:0] cmd, input int n,
                          output logic [15:0] rx);
    shift(8, {8'h00, cmd}, rx);
    shift(n, 16'h0000, rx);
    release_bus();
  endtask
  task automatic stream(output logic [15:0] rx);
    shift(16, 16'h0000, rx);
    release_bus();
  endtask
endmodule
`default_nettype wire
